// ===== rtl/opr_pkg.sv
package opr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bank geometry
    localparam int OPR_NUM_REGS  = 5;
    localparam int OPR_NUM_PINS  = 10;
    localparam int OPR_FIRST_PIN = 22;
    localparam int OPR_SEL_W     = 6;
    localparam int OPR_REG_W     = 16;
    localparam int OPR_NUM_FUNC  = 64;
    localparam int OPR_ADDR_W    = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [OPR_ADDR_W-1:0] OPR_OFS_MAP_22_23 = 8'h00;
    localparam logic [OPR_ADDR_W-1:0] OPR_OFS_MAP_24_25 = 8'h04;
    localparam logic [OPR_ADDR_W-1:0] OPR_OFS_MAP_26_27 = 8'h08;
    localparam logic [OPR_ADDR_W-1:0] OPR_OFS_MAP_28_29 = 8'h0c;
    localparam logic [OPR_ADDR_W-1:0] OPR_OFS_MAP_30_31 = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // field layout and reset values
    localparam int                   OPR_EVEN_LSB  = 0;
    localparam int                   OPR_ODD_LSB   = 8;
    localparam logic [OPR_SEL_W-1:0] OPR_SEL_RESET = 6'h00;
    localparam logic [31:0]          OPR_RDATA_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite codes
    localparam logic [1:0] OPR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] OPR_HTRANS_SEQ    = 2'h3;
    localparam logic       OPR_HRESP_OKAY    = 1'h0;

    typedef enum logic [3:0] {
        OPR_ST_IDLE    = 4'b0001,
        OPR_ST_WRITE   = 4'b0010,
        OPR_ST_RD_WAIT = 4'b0100,
        OPR_ST_RD_DONE = 4'b1000
    } opr_state_t;

endpackage : opr_pkg

// ===== rtl/opr_sel_field.sv
`timescale 1ns/100ps
module opr_sel_field
    import opr_pkg::*;
#(
    parameter bit PRESENT = 1'b1
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 wr_en,
    input  wire logic [OPR_SEL_W-1:0] wr_data,
    output logic      [OPR_SEL_W-1:0] sel
);

    generate
        if (PRESENT) begin : g_field
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    sel <= OPR_SEL_RESET;
                end else if (wr_en) begin
                    sel <= wr_data;
                end
            end
        end else begin : g_absent
            assign sel = OPR_SEL_RESET;
        end
    endgenerate

endmodule : opr_sel_field

// ===== rtl/opr_pin_route.sv
`timescale 1ns/100ps
module opr_pin_route
    import opr_pkg::*;
#(
    parameter int NUM_FUNC = OPR_NUM_FUNC,
    parameter bit PRESENT  = 1'b1
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic [OPR_SEL_W-1:0] sel,
    input  wire logic [NUM_FUNC-1:0]  periph_out,
    output logic                      pin
);

    logic next_pin;

    // function numbers beyond the implemented set drive low
    always_comb begin
        next_pin = 1'b0;
        if (PRESENT && (int'(sel) < NUM_FUNC)) begin
            next_pin = periph_out[sel];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin <= 1'b0;
        end else begin
            pin <= next_pin;
        end
    end

endmodule : opr_pin_route

// ===== rtl/opr_remap_bank.sv
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
//
// Contract
// - a selector field holding n routes peripheral output function n to its pin.
// - bits 15-14 and 7-6 of every mapping register always read as zero.
// - every selector bit is read/write and is cleared to zero by reset.
// - first register holds pin 23 selector in bits 13-8 and pin 22 selector in bits 5-0.
// - second register holds pin 25 selector in bits 13-8 and pin 24 selector in bits 5-0.
// - third register holds pin 27 selector in bits 13-8 and pin 26 selector in bits 5-0.
// - fourth register holds pin 29 selector in bits 13-8 and pin 28 selector in bits 5-0.
// - fifth register holds pin 31 selector in bits 13-8 and pin 30 selector in bits 5-0.
// - in the smaller package variants the pin 31 selector is absent and reads as zero.
//
module opr_remap_bank
    import opr_pkg::*;
#(
    parameter int NUM_FUNC      = OPR_NUM_FUNC,
    parameter bit PIN31_PRESENT = 1'b1
) (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  hsel,
    input  wire logic [OPR_ADDR_W-1:0] haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [31:0]           hrdata,
    input  wire logic [NUM_FUNC-1:0]   periph_out,
    output logic                       remap_pin_22,
    output logic                       remap_pin_23,
    output logic                       remap_pin_24,
    output logic                       remap_pin_25,
    output logic                       remap_pin_26,
    output logic                       remap_pin_27,
    output logic                       remap_pin_28,
    output logic                       remap_pin_29,
    output logic                       remap_pin_30,
    output logic                       remap_pin_31
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    generate
        if (NUM_FUNC < 1 || NUM_FUNC > OPR_NUM_FUNC) begin : g_bad_num_func
            $error("opr_remap_bank: NUM_FUNC must lie between 1 and 64");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    opr_state_t                  state;
    opr_state_t                  next_state;
    logic                        take;
    logic                        ap_write;
    logic [OPR_ADDR_W-1:0]       ap_addr;
    logic [OPR_ADDR_W-1:0]       dp_addr;
    logic [OPR_NUM_REGS-1:0]     dp_hit;
    logic                        write_commit;
    logic [31:0]                 next_rdata;
    logic [OPR_SEL_W-1:0]        pin_sel     [OPR_NUM_PINS];
    logic [OPR_NUM_PINS-1:0]     pin_vec;
    logic [OPR_REG_W-1:0]        reg_view    [OPR_NUM_REGS];

    ////////////////////////////////////////////////////////////////////////////////
    // address phase
    assign take     = hsel && hready && (htrans == OPR_HTRANS_NONSEQ || htrans == OPR_HTRANS_SEQ);
    assign ap_write = hwrite;
    assign ap_addr  = haddr;

    always_comb begin
        next_state = state;
        case (state)
            OPR_ST_IDLE, OPR_ST_WRITE, OPR_ST_RD_DONE: begin
                if (take) begin
                    next_state = ap_write ? OPR_ST_WRITE : OPR_ST_RD_WAIT;
                end else begin
                    next_state = OPR_ST_IDLE;
                end
            end
            OPR_ST_RD_WAIT: begin
                next_state = OPR_ST_RD_DONE;
            end
            default: begin
                next_state = OPR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= OPR_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // address held for the data phase
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dp_addr <= '0;
        end else if (take && hreadyout) begin
            dp_addr <= ap_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data phase
    // reads take one wait state so hrdata comes from a flop
    assign hreadyout    = (state != OPR_ST_RD_WAIT);
    assign hresp        = OPR_HRESP_OKAY;
    assign write_commit = (state == OPR_ST_WRITE);

    // full-address decode; unmapped offsets hit nothing
    always_comb begin
        dp_hit    = '0;
        dp_hit[0] = (dp_addr == OPR_OFS_MAP_22_23);
        dp_hit[1] = (dp_addr == OPR_OFS_MAP_24_25);
        dp_hit[2] = (dp_addr == OPR_OFS_MAP_26_27);
        dp_hit[3] = (dp_addr == OPR_OFS_MAP_28_29);
        dp_hit[4] = (dp_addr == OPR_OFS_MAP_30_31);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // selector fields and pin routing
    genvar f;
    generate
        for (f = 0; f < OPR_NUM_PINS; f++) begin : g_pin
            localparam int  REG_IDX = f / 2;
            localparam int  LSB     = (f % 2 == 1) ? OPR_ODD_LSB : OPR_EVEN_LSB;
            localparam bit  PRES    = (f == OPR_NUM_PINS - 1) ? PIN31_PRESENT : 1'b1;
            logic                 fld_wr;
            logic [OPR_SEL_W-1:0] fld_data;

            // only the six selector bits reach the field
            assign fld_wr   = write_commit && dp_hit[REG_IDX];
            assign fld_data = hwdata[LSB +: OPR_SEL_W];

            opr_sel_field #(
                .PRESENT (PRES)
            ) u_field (
                .ref_clk (ref_clk),
                .resetn  (resetn),
                .wr_en   (fld_wr),
                .wr_data (fld_data),
                .sel     (pin_sel[f])
            );

            opr_pin_route #(
                .NUM_FUNC (NUM_FUNC),
                .PRESENT  (PRES)
            ) u_route (
                .ref_clk    (ref_clk),
                .resetn     (resetn),
                .sel        (pin_sel[f]),
                .periph_out (periph_out),
                .pin        (pin_vec[f])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register views
    always_comb begin
        reg_view[0] = {2'b00, pin_sel[1], 2'b00, pin_sel[0]};
        reg_view[1] = {2'b00, pin_sel[3], 2'b00, pin_sel[2]};
        reg_view[2] = {2'b00, pin_sel[5], 2'b00, pin_sel[4]};
        reg_view[3] = {2'b00, pin_sel[7], 2'b00, pin_sel[6]};
        reg_view[4] = {2'b00, pin_sel[9], 2'b00, pin_sel[8]};
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = OPR_RDATA_RST;
        for (int r = 0; r < OPR_NUM_REGS; r++) begin
            if (dp_hit[r]) begin
                next_rdata = {16'h0000, reg_view[r]};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= OPR_RDATA_RST;
        end else if (state == OPR_ST_RD_WAIT) begin
            hrdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin outputs
    assign remap_pin_22 = pin_vec[0];
    assign remap_pin_23 = pin_vec[1];
    assign remap_pin_24 = pin_vec[2];
    assign remap_pin_25 = pin_vec[3];
    assign remap_pin_26 = pin_vec[4];
    assign remap_pin_27 = pin_vec[5];
    assign remap_pin_28 = pin_vec[6];
    assign remap_pin_29 = pin_vec[7];
    assign remap_pin_30 = pin_vec[8];
    assign remap_pin_31 = pin_vec[9];

endmodule : opr_remap_bank

// ===== test/opr_remap_bank_asserts.sv
`timescale 1ns/100ps
module opr_remap_bank_asserts
    import opr_pkg::*;
#(
    parameter int NUM_FUNC      = OPR_NUM_FUNC,
    parameter bit PIN31_PRESENT = 1'b1
) (
    input wire logic                ref_clk,
    input wire logic                resetn,
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    input wire logic [NUM_FUNC-1:0] periph_out,
    input wire logic                remap_pin_22,
    input wire logic                remap_pin_27,
    input wire logic                remap_pin_31
);
    logic rd_taken;
    logic wr_taken;
    assign rd_taken = hsel && hready && htrans[1] && !hwrite;
    assign wr_taken = hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    AST_OKAY: assert property (hresp == OPR_HRESP_OKAY)
        else $error("hresp not okay");
    AST_RSVD_ZERO: assert property (hrdata[15:14] == 2'h0 && hrdata[7:6] == 2'h0)
        else $error("reserved read bits set");
    AST_UPPER_ZERO: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_RD_WAIT: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (wr_taken |=> hreadyout)
        else $error("write stalled");
    AST_WAIT_CAUSE: assert property ($fell(hreadyout) |-> $past(rd_taken))
        else $error("stall without read");
    AST_HOLD: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data moved");
    AST_ALL_LO: assert property ($past(resetn) && $past(periph_out) == '0 |->
        !remap_pin_22 && !remap_pin_27 && !remap_pin_31) else $error("pin high with no source");
    AST_ALL_HI: assert property (NUM_FUNC == OPR_NUM_FUNC && $past(resetn) && (&$past(periph_out)) |->
        remap_pin_22 && remap_pin_27 && (remap_pin_31 || !PIN31_PRESENT)) else $error("pin low with all sources high");
    AST_PIN31: assert property (!PIN31_PRESENT |-> !remap_pin_31)
        else $error("absent pin driven");
endmodule : opr_remap_bank_asserts

// ===== test/tb_opr_remap_bank.sv
`timescale 1ns/100ps
module tb_opr_remap_bank
    import opr_pkg::*;
;
    logic                    ref_clk, resetn, hsel, hwrite, hready, hreadyout, hreadyout2, hresp, hresp2;
    logic [OPR_ADDR_W-1:0]   haddr;
    logic [1:0]              htrans;
    logic [2:0]              hsize;
    logic [31:0]             hwdata, hrdata, hrdata2, rd, rd2, d;
    logic [OPR_NUM_FUNC-1:0] periph_out;
    localparam int           SMALL_FUNC = 48;
    logic [9:0]              pins, pins2, e, e2;
    logic [5:0]              s;
    logic [15:0]             m [5];
    int                      n_mismatch, cmp_count, seed;
    assign hready = hreadyout;
    always #12.5 ref_clk = ~ref_clk;
    opr_remap_bank u_dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .periph_out(periph_out), .remap_pin_22(pins[0]), .remap_pin_23(pins[1]),
        .remap_pin_24(pins[2]), .remap_pin_25(pins[3]), .remap_pin_26(pins[4]), .remap_pin_27(pins[5]),
        .remap_pin_28(pins[6]), .remap_pin_29(pins[7]), .remap_pin_30(pins[8]), .remap_pin_31(pins[9]));
    opr_remap_bank #(.NUM_FUNC(SMALL_FUNC), .PIN31_PRESENT(1'b0)) u_small (.ref_clk(ref_clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout2), .hresp(hresp2), .hrdata(hrdata2),
        .periph_out(periph_out[SMALL_FUNC-1:0]),
        .remap_pin_22(pins2[0]), .remap_pin_23(pins2[1]), .remap_pin_24(pins2[2]), .remap_pin_25(pins2[3]),
        .remap_pin_26(pins2[4]), .remap_pin_27(pins2[5]), .remap_pin_28(pins2[6]), .remap_pin_29(pins2[7]),
        .remap_pin_30(pins2[8]), .remap_pin_31(pins2[9]));
    ////////////////////////////////////////
    task test_done();
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task wt();
        for (int k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (hready === 1'b1) return;
        end
        n_mismatch++;
        test_done();
    endtask : wt
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr <= a;
        hwrite <= w;
        htrans <= OPR_HTRANS_NONSEQ;
        wt();
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
        rd = hrdata;
        rd2 = hrdata2;
    endtask : xfer
    task rdall();
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            chk("readback", {16'h0, m[i]}, rd);
            chk("small readback", {16'h0, (i == 4) ? (m[i] & 16'h003f) : m[i]}, rd2);
        end
    endtask : rdall
    task pchk();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        for (int j = 0; j < 10; j++) begin
            s = m[j / 2][(j % 2) * 8 +: 6];
            e[j] = periph_out[s];
            e2[j] = (j < 9 && s < SMALL_FUNC) ? periph_out[s] : 1'b0;
        end
        chk("pins", {22'h0, e}, {22'h0, pins});
        chk("small pins", {22'h0, e2}, {22'h0, pins2});
        @(posedge ref_clk);
    endtask : pchk
    ////////////////////////////////////////
    initial begin
        ref_clk = 0; resetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
        periph_out = '1; seed = 96; n_mismatch = 0; cmp_count = 0;
        foreach (m[i]) m[i] = 16'h0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        hsel <= 1'b1;
        pchk();
        rdall();
        for (int r = 0; r < 10; r++) begin
            for (int i = 0; i < 5; i++) begin
                d = $random(seed);
                xfer(1'b1, 8'(4 * i), d);
                m[i] = d[15:0] & 16'h3f3f;
            end
            periph_out <= (r == 9) ? '0 : {$random(seed), $random(seed)};
            pchk();
            rdall();
        end
        xfer(1'b1, 8'h14, 32'hffff_ffff);
        xfer(1'b1, 8'h02, 32'hffff_ffff);
        xfer(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        rdall();
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (m[i]) m[i] = 16'h0;
        periph_out <= {$random(seed), $random(seed)};
        pchk();
        rdall();
        test_done();
    end
endmodule : tb_opr_remap_bank
bind opr_remap_bank opr_remap_bank_asserts #(.NUM_FUNC(NUM_FUNC), .PIN31_PRESENT(PIN31_PRESENT)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph_out(periph_out),
    .remap_pin_22(remap_pin_22), .remap_pin_27(remap_pin_27), .remap_pin_31(remap_pin_31));
